// *** logic/ppfm_cfg.svh ***
// constants of the printer-port floppy mux
// assumes an 8-bit register port with byte addresses
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH
`define PPFM_ADR_DATA 8'h00
`define PPFM_ADR_STAT 8'h01
`define PPFM_ADR_CTRL 8'h02
`define PPFM_ADR_CFG1 8'h10
`define PPFM_ADR_CFG4 8'h14
`define PPFM_ADR_LCFG 8'h18
`define PPFM_ADR_DSEL 8'h1C
`define PPFM_BIT_POWER 2
`define PPFM_BIT_MODE_LO 2
`define PPFM_BIT_MODE_HI 3
`define PPFM_BIT_EXT_CAP 0
`define PPFM_BIT_DMA 1
`define PPFM_BIT_IRQLOW 2
`define PPFM_BIT_DIR 5
`define PPFM_RST_CFG1 8'h04
`define PPFM_RST_ZERO 8'h00
`define PPFM_STAT_REMOTE 8'h48
`define PPFM_CTRL_REMOTE 4'h4
`endif

// *** logic/ppfm_pkg.sv ***
// types of the printer-port floppy mux
// assumes ppfm_cfg.svh holds the numbers
package ppfm_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic strobe_low;
    logic autofeed_low;
    logic init_low;
    logic select_in_low;
    logic ack_low;
    logic busy;
    logic paper_end;
    logic selected;
    logic fault_low;
  } ppfm_lpt_type;
  typedef struct packed {
    logic write_stream_low;
    logic density_select;
    logic head_select_low;
    logic write_gate_low;
    logic step_direction_low;
    logic step_pulse_low;
    logic drive_select0_low;
    logic drive_select1_low;
    logic motor_on0_low;
    logic motor_on1_low;
  } ppfm_fdd_out_type;
  typedef struct packed {
    logic index_pulse_low;
    logic track_zero_low;
    logic write_protect_low;
    logic read_stream_low;
    logic disk_changed_low;
  } ppfm_fdd_in_type;
  typedef enum logic [2:0] {
    PPFM_NORMAL = 3'h1,
    PPFM_ONE = 3'h2,
    PPFM_TWO = 3'h4
  } ppfm_mode_type;
endpackage

// *** logic/ppfm_mux.sv ***
// printer-port floppy mux with register port and pin steering
// assumes pins outside i_clk domain, floppy core on i_clk
//
// Behaviour
// - remote floppy mode takes the printer port away from printer use
// - one-drive mode: drive 1 remote; two-drive mode: drives 0 and 1 remote
// - mode chosen by two bits of config register 4; either enables remote
// - remote: dma request hi-z, or driven 0 when extended mode and dma allowed
// - remote: printer interrupt inactive, hi-z or low by configuration
// - remote: dma acknowledge stays routed to printer function
// - remote: data register reads back last written value
// - remote: control bits 3-0 read as cable absent, init 1, others 0; bits 7-4 read as written
// - remote: status reads busy-low, paper, select 0; ack-low, fault-low 1
// - native floppy outputs tri-state while a remote drive is selected
// - data 0-4 floppy inputs; status and control lines carry floppy outputs
// - strobe and data 6 carry select0 and motor0, outputs only two-drive
// - remote floppy works regardless of printer power bit
// - no mode bit: printer follows power; any mode bit: floppy on, printer off
`include "ppfm_cfg.svh"
module ppfm_mux (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire ppfm_pkg::ppfm_fdd_out_type i_fdc,
  output ppfm_pkg::ppfm_fdd_in_type o_fdc_in,
  input wire ppfm_pkg::ppfm_fdd_in_type i_native,
  output ppfm_pkg::ppfm_fdd_out_type o_native,
  output logic o_native_oe,
  input wire ppfm_pkg::ppfm_lpt_type i_lpt,
  output ppfm_pkg::ppfm_lpt_type o_lpt,
  output ppfm_pkg::ppfm_lpt_type o_lpt_oe,
  input wire logic i_lpt_dma_req,
  input wire logic i_lpt_irq,
  output logic o_dma_req,
  output logic o_dma_req_oe,
  output logic o_irq,
  output logic o_irq_oe,
  input wire logic i_dma_ack_low,
  output logic o_lpt_dma_ack_low,
  output logic o_remote_active
);
  logic [7:0] data_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] cfg1;
  logic [7:0] cfg4;
  logic [7:0] lcfg;
  logic [1:0] dsel;
  ppfm_pkg::ppfm_mode_type mode;
  ppfm_pkg::ppfm_mode_type next_mode;
  ppfm_pkg::ppfm_lpt_type lpt_s1;
  ppfm_pkg::ppfm_lpt_type lpt_s2;
  ppfm_pkg::ppfm_fdd_in_type nat_s1;
  ppfm_pkg::ppfm_fdd_in_type nat_s2;
  logic ack_s1;
  logic ack_s2;

  function automatic logic remote_sel(input ppfm_pkg::ppfm_mode_type m,
                                      input logic [1:0] ds);
    case (m)
      ppfm_pkg::PPFM_ONE: remote_sel = (ds == 2'h1);
      ppfm_pkg::PPFM_TWO: remote_sel = (ds == 2'h0) || (ds == 2'h1);
      default: remote_sel = 1'b0;
    endcase
  endfunction

  // mode decode from config register 4
  wire mode_hi = cfg4[`PPFM_BIT_MODE_HI];
  wire mode_lo = cfg4[`PPFM_BIT_MODE_LO];
  assign next_mode = mode_hi ? ppfm_pkg::PPFM_TWO :
                     mode_lo ? ppfm_pkg::PPFM_ONE : ppfm_pkg::PPFM_NORMAL;
  wire remote = (mode != ppfm_pkg::PPFM_NORMAL);
  wire two = (mode == ppfm_pkg::PPFM_TWO);
  wire power = cfg1[`PPFM_BIT_POWER];
  wire lpt_on = power && !remote;
  wire drv_remote = remote_sel(mode, dsel);
  wire ext_cap = lcfg[`PPFM_BIT_EXT_CAP];
  wire dma_ok = lcfg[`PPFM_BIT_DMA];
  wire irq_low = lcfg[`PPFM_BIT_IRQLOW];

  // register decode
  wire hit_data = (i_addr == `PPFM_ADR_DATA);
  wire hit_stat = (i_addr == `PPFM_ADR_STAT);
  wire hit_ctrl = (i_addr == `PPFM_ADR_CTRL);
  wire hit_cfg1 = (i_addr == `PPFM_ADR_CFG1);
  wire hit_cfg4 = (i_addr == `PPFM_ADR_CFG4);
  wire hit_lcfg = (i_addr == `PPFM_ADR_LCFG);
  wire hit_dsel = (i_addr == `PPFM_ADR_DSEL);

  // status and control read values
  wire [7:0] stat_live = {~lpt_s2.busy, lpt_s2.ack_low, lpt_s2.paper_end,
                          lpt_s2.selected, lpt_s2.fault_low, 3'h0};
  wire [7:0] stat_rd = remote ? `PPFM_STAT_REMOTE : stat_live;
  wire [7:0] ctrl_rd = remote ? {ctrl_reg[7:4], `PPFM_CTRL_REMOTE}
                              : ctrl_reg;
  wire [7:0] next_rdata =
    !i_rd ? 8'h00 :
    hit_data ? data_reg :
    hit_stat ? stat_rd :
    hit_ctrl ? ctrl_rd :
    hit_cfg1 ? cfg1 :
    hit_cfg4 ? cfg4 :
    hit_lcfg ? lcfg :
    hit_dsel ? {6'h00, dsel} : 8'h00;

  // printer pins while floppy is remote
  ppfm_pkg::ppfm_lpt_type lpt_rem;
  ppfm_pkg::ppfm_lpt_type lpt_rem_oe;
  ppfm_pkg::ppfm_lpt_type lpt_spp;
  ppfm_pkg::ppfm_lpt_type lpt_spp_oe;
  assign lpt_rem = '{
    data: {1'b0, i_fdc.motor_on0_low, 6'h00},
    strobe_low: i_fdc.drive_select0_low,
    autofeed_low: i_fdc.density_select,
    init_low: i_fdc.step_direction_low,
    select_in_low: i_fdc.step_pulse_low,
    ack_low: i_fdc.drive_select1_low,
    busy: i_fdc.motor_on1_low,
    paper_end: i_fdc.write_stream_low,
    selected: i_fdc.write_gate_low,
    fault_low: i_fdc.head_select_low
  };
  assign lpt_rem_oe = '{
    data: {1'b0, two, 6'h00},
    strobe_low: two,
    autofeed_low: 1'b1,
    init_low: 1'b1,
    select_in_low: 1'b1,
    ack_low: 1'b1,
    busy: 1'b1,
    paper_end: 1'b1,
    selected: 1'b1,
    fault_low: 1'b1
  };
  // plain printer pins from the data and control registers
  assign lpt_spp = '{
    data: data_reg,
    strobe_low: ~ctrl_reg[0],
    autofeed_low: ~ctrl_reg[1],
    init_low: ctrl_reg[2],
    select_in_low: ~ctrl_reg[3],
    ack_low: 1'b0,
    busy: 1'b0,
    paper_end: 1'b0,
    selected: 1'b0,
    fault_low: 1'b0
  };
  wire dout = lpt_on && !ctrl_reg[`PPFM_BIT_DIR];
  assign lpt_spp_oe = '{
    data: {8{dout}},
    strobe_low: lpt_on,
    autofeed_low: lpt_on,
    init_low: lpt_on,
    select_in_low: lpt_on,
    ack_low: 1'b0,
    busy: 1'b0,
    paper_end: 1'b0,
    selected: 1'b0,
    fault_low: 1'b0
  };
  ppfm_pkg::ppfm_lpt_type next_lpt;
  ppfm_pkg::ppfm_lpt_type next_lpt_oe;
  assign next_lpt = remote ? lpt_rem : lpt_spp;
  assign next_lpt_oe = remote ? lpt_rem_oe : lpt_spp_oe;

  // floppy inputs taken from printer data lines for remote drive
  ppfm_pkg::ppfm_fdd_in_type fdd_rem;
  ppfm_pkg::ppfm_fdd_in_type next_fdc_in;
  assign fdd_rem = '{
    index_pulse_low: lpt_s2.data[0],
    track_zero_low: lpt_s2.data[1],
    write_protect_low: lpt_s2.data[2],
    read_stream_low: lpt_s2.data[3],
    disk_changed_low: lpt_s2.data[4]
  };
  assign next_fdc_in = drv_remote ? fdd_rem : nat_s2;

  // dma request and interrupt
  wire next_dma_oe = remote ? (ext_cap && dma_ok) : (lpt_on && ext_cap);
  wire next_dma = remote ? 1'b0 : i_lpt_dma_req;
  wire next_irq = remote ? 1'b0 : i_lpt_irq;
  wire next_irq_oe = remote ? irq_low : lpt_on;

  // pin synchronisers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lpt_s1 <= '0;
      lpt_s2 <= '0;
      nat_s1 <= '0;
      nat_s2 <= '0;
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
    end else begin
      lpt_s1 <= i_lpt;
      lpt_s2 <= lpt_s1;
      nat_s1 <= i_native;
      nat_s2 <= nat_s1;
      ack_s1 <= i_dma_ack_low;
      ack_s2 <= ack_s1;
    end
  end

  // software registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_reg <= `PPFM_RST_ZERO;
      ctrl_reg <= `PPFM_RST_ZERO;
      cfg1 <= `PPFM_RST_CFG1;
      cfg4 <= `PPFM_RST_ZERO;
      lcfg <= `PPFM_RST_ZERO;
      dsel <= 2'h0;
    end else if (i_wr) begin
      if (hit_data) data_reg <= i_wdata;
      if (hit_ctrl) ctrl_reg <= i_wdata;
      if (hit_cfg1) cfg1 <= i_wdata;
      if (hit_cfg4) cfg4 <= i_wdata;
      if (hit_lcfg) lcfg <= i_wdata;
      if (hit_dsel) dsel <= i_wdata[1:0];
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= ppfm_pkg::PPFM_NORMAL;
      o_rdata <= 8'h00;
      o_fdc_in <= '1;
      o_native <= '1;
      o_native_oe <= 1'b0;
      o_lpt <= '0;
      o_lpt_oe <= '0;
      o_dma_req <= 1'b0;
      o_dma_req_oe <= 1'b0;
      o_irq <= 1'b0;
      o_irq_oe <= 1'b0;
      o_lpt_dma_ack_low <= 1'b1;
      o_remote_active <= 1'b0;
    end else begin
      mode <= next_mode;
      o_rdata <= next_rdata;
      o_fdc_in <= next_fdc_in;
      o_native <= i_fdc;
      o_native_oe <= !drv_remote;
      o_lpt <= next_lpt;
      o_lpt_oe <= next_lpt_oe;
      o_dma_req <= next_dma;
      o_dma_req_oe <= next_dma_oe;
      o_irq <= next_irq;
      o_irq_oe <= next_irq_oe;
      o_lpt_dma_ack_low <= ack_s2;
      o_remote_active <= remote;
    end
  end

  AST_STAT_FIXED: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && hit_stat && remote) |=> (o_rdata == `PPFM_STAT_REMOTE))
    else $error("status read wrong in remote mode");
  AST_CTRL_CABLE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && hit_ctrl && remote) |=> (o_rdata[3:0] == `PPFM_CTRL_REMOTE))
    else $error("control read not cable absent");
  AST_DATA_ECHO: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && hit_data) ##1 (i_rd && hit_data) |=> (o_rdata == $past(i_wdata, 2)))
    else $error("data read differs from last write");
  AST_NATIVE_HIZ: assert property (
    @(posedge i_clk) disable iff (i_rst)
    drv_remote |=> !o_native_oe)
    else $error("native outputs driven with remote drive");
  AST_DMA_REQ: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remote |=> (o_dma_req == 1'b0) && (o_dma_req_oe == $past(ext_cap && dma_ok)))
    else $error("dma request wrong in remote mode");
  AST_IRQ_QUIET: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remote |=> !o_irq && (o_irq_oe == $past(irq_low)))
    else $error("printer interrupt active in remote mode");
  AST_STB_DIR: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remote |=> (o_lpt_oe.strobe_low == $past(two)) && (o_lpt_oe.data[6] == $past(two)))
    else $error("strobe or data6 direction wrong");
  AST_POWER_FREE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (remote && !power) |=> o_lpt_oe.ack_low && o_lpt_oe.select_in_low)
    else $error("remote pins follow power bit");
  AST_STEP_MAP: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remote |=> (o_lpt.select_in_low == $past(i_fdc.step_pulse_low)) && (o_lpt_oe.data[4:0] == 5'h00))
    else $error("step not on select-in pin");
  AST_MODE_LAT: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && hit_cfg4 && (i_wdata[3:2] != 2'h0)) |=> ##1 remote)
    else $error("mode bit did not enable remote");
endmodule

// *** bench/ppfm_drive_model.sv ***
// floppy drive hanging on the printer connector, behavioural
// assumes an oe bit is high while the mux drives that line
module ppfm_drive_model (
  input wire logic i_clk,
  input wire ppfm_pkg::ppfm_lpt_type i_pin,
  input wire ppfm_pkg::ppfm_lpt_type i_pin_oe,
  input wire ppfm_pkg::ppfm_fdd_in_type i_status,
  output ppfm_pkg::ppfm_lpt_type o_pin
);
  ppfm_pkg::ppfm_lpt_type drv;
  logic sel;
  logic flip = 1'b0;
  logic [4:0] stat_bits;
  // drive status placed on data 0-4: index, track zero, protect, read, change
  assign stat_bits = {i_status.disk_changed_low, i_status.read_stream_low, i_status.write_protect_low,
                      i_status.track_zero_low, i_status.index_pulse_low};
  // selected while either select line is driven low
  assign sel = (i_pin_oe.ack_low & ~i_pin.ack_low) | (i_pin_oe.strobe_low & ~i_pin.strobe_low);
  always_ff @(posedge i_clk) begin
    flip <= ~flip;
  end
  always_comb begin
    // pull-ups on every printer line
    drv = '1;
    // status on data 0-4 only while selected, else a changing pattern
    drv.data[4:0] = sel ? stat_bits : ({5{flip}} ^ ~stat_bits);
  end
  assign o_pin = (i_pin & i_pin_oe) | (drv & ~i_pin_oe);
endmodule

// *** bench/ppfm_mux_tb.sv ***
// self-checking bench of the printer-port floppy mux
// assumes the drive model resolves the printer pins
`include "ppfm_cfg.svh"
module ppfm_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_wr, i_rd, i_lpt_dma_req, i_lpt_irq, i_dma_ack_low;
  logic [7:0] i_addr, i_wdata, o_rdata;
  ppfm_pkg::ppfm_fdd_out_type i_fdc, o_native;
  ppfm_pkg::ppfm_fdd_in_type o_fdc_in, i_native;
  ppfm_pkg::ppfm_lpt_type i_lpt, o_lpt, o_lpt_oe;
  logic o_native_oe, o_dma_req, o_dma_req_oe, o_irq, o_irq_oe, o_lpt_dma_ack_low, o_remote_active;
  ppfm_pkg::ppfm_fdd_in_type status = 5'h16;
  int errors = 0;
  int cmp_count = 0;
  ppfm_mux DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fdc, .o_fdc_in, .i_native,
    .o_native, .o_native_oe, .i_lpt, .o_lpt, .o_lpt_oe, .i_lpt_dma_req, .i_lpt_irq, .o_dma_req,
    .o_dma_req_oe, .o_irq, .o_irq_oe, .i_dma_ack_low, .o_lpt_dma_ack_low, .o_remote_active);
  ppfm_drive_model drive (.i_clk(i_clk), .i_pin(o_lpt), .i_pin_oe(o_lpt_oe), .i_status(status), .o_pin(i_lpt));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, d);
  endtask
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset;
    rdchk(`PPFM_ADR_CFG1, 8'h04);
    rdchk(`PPFM_ADR_CFG4, 8'h00);
    rdchk(8'h33, 8'h00);
    settle();
    chk(o_remote_active, 1'b0);
    chk(o_native_oe, 1'b1);
    rdchk(`PPFM_ADR_STAT, 8'h78);
    chk(o_irq_oe, 1'b1);
    wr(`PPFM_ADR_CFG1, 8'h00);
    settle();
    chk(o_irq_oe, 1'b0);
    wr(`PPFM_ADR_CFG1, 8'h04);
  endtask
  task automatic t_one;
    wr(`PPFM_ADR_CFG4, 8'h04);
    wr(`PPFM_ADR_DATA, 8'hA5);
    wr(`PPFM_ADR_CTRL, 8'h2F);
    wr(`PPFM_ADR_DSEL, 8'h01);
    i_fdc.drive_select1_low <= 1'b0;
    i_lpt_dma_req <= 1'b1;
    settle();
    chk(o_remote_active, 1'b1);
    chk(o_native_oe, 1'b0);
    chk({o_lpt_oe.strobe_low, o_lpt_oe.data[6]}, 2'h0);
    chk({o_lpt_oe.ack_low, o_lpt.ack_low}, 2'h2);
    chk(o_fdc_in, status);
    chk(o_dma_req_oe, 1'b0);
    chk(o_irq_oe, 1'b0);
    rdchk(`PPFM_ADR_STAT, 8'h48);
    rdchk(`PPFM_ADR_CTRL, 8'h24);
    rdchk(`PPFM_ADR_DATA, 8'hA5);
    wr_rd(`PPFM_ADR_DATA, 8'h3C);
    wr(`PPFM_ADR_DSEL, 8'h00);
    settle();
    chk(o_native_oe, 1'b1);
    chk(o_fdc_in, i_native);
  endtask
  task automatic t_two;
    wr(`PPFM_ADR_CFG4, 8'h08);
    wr(`PPFM_ADR_CFG1, 8'h00);
    i_fdc.drive_select0_low <= 1'b0;
    i_fdc.step_pulse_low <= 1'b0;
    i_fdc.density_select <= 1'b1;
    i_dma_ack_low <= 1'b0;
    settle();
    chk(o_native_oe, 1'b0);
    chk({o_lpt_oe.strobe_low, o_lpt.strobe_low, o_lpt_oe.data[6]}, 3'h5);
    chk({o_lpt_oe.select_in_low, o_lpt.select_in_low, o_lpt.autofeed_low}, 3'h5);
    chk(o_fdc_in, status);
    chk(o_lpt_dma_ack_low, 1'b0);
    chk(o_native, i_fdc);
    rdchk(`PPFM_ADR_STAT, 8'h48);
    for (int k = 0; k < 8; k++) begin
      wr(`PPFM_ADR_LCFG, 8'(k));
      settle();
      chk(o_dma_req_oe, 1'(k[1:0] == 2'h3));
      chk({o_dma_req_oe, o_dma_req}, {1'(k[1:0] == 2'h3), 1'b0});
      chk({o_irq_oe, o_irq}, {k[2], 1'b0});
    end
  endtask
  task automatic t_back;
    wr(`PPFM_ADR_CFG4, 8'h00);
    wr(`PPFM_ADR_CFG1, 8'h04);
    settle();
    chk(o_remote_active, 1'b0);
    chk(o_native_oe, 1'b1);
    rdchk(`PPFM_ADR_STAT, 8'h78);
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    end_sim();
  end
  initial begin
    i_rst = 1'b1;
    {i_wr, i_rd, i_lpt_dma_req, i_lpt_irq} = 4'h1;
    i_dma_ack_low = 1'b1;
    {i_addr, i_wdata} = 16'h0000;
    i_fdc = '1;
    i_native = 5'h0B;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_one();
    t_two();
    t_back();
    end_sim();
  end
endmodule
